// >>> rtl/frc_pkg.sv
// Purpose: Constants and types for the fault collector and reset generator.
// Assumes: AXI4-Lite register access with 32-bit data and one 40 MHz clock.
// Notes:   Offsets are byte addresses; every register takes one aligned word.
//
// Notes on behaviour
// - Every enabled fault source is latched and reacted to without processor help.
// - Per fault reaction is none, interrupt, NMI or functional reset, plus error pins.
// - Supervisor requests a reset when the collector fails to report a fault or configuration state overruns its limit.
// - Supervisor bounds configuration state to 1000h internal RC oscillator cycles.
// - Two error pins, both undriven while in reset.
// - In single pin mode error pin 0 is the only one driven.
// - Enable, reaction and timeout registers take writes only in configuration state.
// - Reporting on the error pins is always on and cannot be disabled.
// - With pad power down set, safe mode forces system pads to high impedance.
// - Reset event disable clear lets reset; disabled events raise the alternate request.
// - Run state write of 0000b gives functional, 1111b destructive reset.
// - Enabled escalation counts functional resets and fires destructive reset at threshold.
// - Escalation counter clears on software write, destructive or power-on reset.
// - Escalation is off after reset; a non-zero threshold write enables it.
// - Test mode, and debug mode with debug enable low, are fault conditions.
package frc_pkg;
   localparam int ADDR_W     = 8;
   localparam int MAX_FAULTS = 16;
   localparam int ESC_W      = 4;

   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_FAULT_EN   = 8'h04;
   localparam logic [7:0] OFS_REACTION   = 8'h08;
   localparam logic [7:0] OFS_TIMEOUT_EN = 8'h0C;
   localparam logic [7:0] OFS_STATUS     = 8'h10;
   localparam logic [7:0] OFS_EVT_DIS    = 8'h14;
   localparam logic [7:0] OFS_ALT_REQ    = 8'h18;
   localparam logic [7:0] OFS_ESC_THR    = 8'h1C;
   localparam logic [7:0] OFS_RUN_CTRL   = 8'h20;
   localparam logic [7:0] OFS_SAFE_CFG   = 8'h24;

   localparam int CTRL_CFG_BIT    = 0;
   localparam int SAFE_PDO_BIT    = 0;
   localparam int SAFE_SINGLE_BIT = 1;

   localparam logic [15:0] RST_FAULT_EN = 16'hFFFF;
   localparam logic [31:0] RST_REACTION = 32'h0000_0000;
   localparam logic [15:0] RST_TOE      = 16'h0000;
   localparam logic [15:0] RST_EVT_DIS  = 16'hFFFF;
   localparam logic [15:0] RST_ALT_REQ  = 16'h0000;
   localparam logic [3:0]  RST_ESC_THR  = 4'h0;

   localparam logic [1:0] RX_NONE   = 2'h0;
   localparam logic [1:0] RX_IRQ    = 2'h1;
   localparam logic [1:0] RX_NMI    = 2'h2;
   localparam logic [1:0] RX_FRESET = 2'h3;

   localparam logic [3:0] RUN_FUNC = 4'h0;
   localparam logic [3:0] RUN_DEST = 4'hF;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int CLK_PERIOD_NS     = 25;
   localparam int FAULT_TIMEOUT_NS  = 1000;
   localparam int FAULT_TIMEOUT_CYC = (FAULT_TIMEOUT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                      FAULT_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam logic [12:0] CFG_LIMIT_RC    = 13'h1000;
   localparam logic [2:0]  REACT_LIMIT_CYC = 3'h4;

   typedef enum logic [1:0] {
      FRC_NORMAL = 2'b00,
      FRC_CONFIG = 2'b01,
      FRC_FAULT  = 2'b10
   } frc_state_t;
endpackage : frc_pkg

// >>> rtl/frc_sync2.sv
// Purpose: Two flip-flop synchroniser for a vector of independent levels.
// Assumes: Each bit is a slow level; bits are not sampled as a coherent word.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps
module frc_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   if (W < 1) begin : g_chk
      $error("frc_sync2 needs W of at least 1");
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : frc_sync2

// >>> rtl/frc_fault_reset.sv
// Purpose: Fault collector, output supervisor and reset generator with escalation.
// Assumes: rst is power-on or destructive reset; funcRst is the functional reset.
// Notes:   Configuration, flags and escalation survive a functional reset.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module frc_fault_reset #(
   parameter int NUM_EXT = 8
) (
   // Clock and resets
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       funcRst,
   // Fault sources and pins
   input  wire logic [NUM_EXT-1:0]         faultIn,
   input  wire logic                       factoryTestPin,
   input  wire logic                       debugEnablePin,
   input  wire logic                       debugActive,
   input  wire logic                       internalRcOsc,
   // Error pins
   output logic      [1:0]                 errOut,
   output logic      [1:0]                 errOutOe,
   // Reactions and reset requests
   output logic                            irqReq,
   output logic                            nmiReq,
   output logic                            funcResetReq,
   output logic                            destResetReq,
   output logic                            supervisorRstReq,
   output logic                            padHiZ,
   // AXI4-Lite write
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [frc_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       wvalid,
   output logic                            wready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   output logic                            bvalid,
   input  wire logic                       bready,
   output logic      [1:0]                 bresp,
   // AXI4-Lite read
   input  wire logic                       arvalid,
   output logic                            arready,
   input  wire logic [frc_pkg::ADDR_W-1:0] araddr,
   output logic                            rvalid,
   input  wire logic                       rready,
   output logic      [31:0]                rdata,
   output logic      [1:0]                 rresp
);
   import frc_pkg::*;

   localparam int NF = NUM_EXT + 2;
   localparam int NS = NUM_EXT + 4;

   if (NUM_EXT < 1 || NF > MAX_FAULTS) begin : g_chk
      $error("frc_fault_reset supports 1 to 14 external fault inputs");
   end

   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      return a == OFS_CTRL || a == OFS_FAULT_EN || a == OFS_REACTION ||
             a == OFS_TIMEOUT_EN || a == OFS_STATUS || a == OFS_EVT_DIS ||
             a == OFS_ALT_REQ || a == OFS_ESC_THR || a == OFS_RUN_CTRL ||
             a == OFS_SAFE_CFG;
   endfunction : isMapped

   function automatic logic isLocked(input logic [ADDR_W-1:0] a);
      return a == OFS_FAULT_EN || a == OFS_REACTION || a == OFS_TIMEOUT_EN;
   endfunction : isLocked

   frc_state_t            state;
   frc_state_t            next_state;
   logic [NF-1:0]         status;
   logic [NF-1:0]         faultEn;
   logic [2*NF-1:0]       reaction;
   logic [NF-1:0]         toe;
   logic [NF-1:0]         evtDis;
   logic [NF-1:0]         altReq;
   logic [ESC_W-1:0]      escThr;
   logic [ESC_W-1:0]      escCnt;
   logic                  pad_power_down;
   logic                  singlePin;
   logic                  errLvl;
   logic [1:0]            errOeReg;
   logic [12:0]           cfgRcCnt;
   logic                  rcPrev;
   logic [2:0]            reactCnt;
   logic [7:0]            toCnt;
   logic                  funcRstPrev;
   logic                  awHeld;
   logic                  wHeld;
   logic [ADDR_W-1:0]     wa;
   logic [31:0]           wDataQ;
   logic [3:0]            wStrbQ;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and fault sources.
   logic [NS-1:0] pinsRaw;
   logic [NS-1:0] pinsSync;
   logic [NF-1:0] faultRaw;
   logic          rcEdge;

   assign pinsRaw = {internalRcOsc, debugActive, debugEnablePin, factoryTestPin, faultIn};

   frc_sync2 #(.W(NS)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   (pinsRaw),
      .q   (pinsSync)
   );

   // Debug entry is only a fault while the debug enable pin is low.
   assign faultRaw = {pinsSync[NS-2] & ~pinsSync[NS-3], pinsSync[NS-4],
                      pinsSync[NUM_EXT-1:0]};
   assign rcEdge   = pinsSync[NS-1] & ~rcPrev;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register bus decode.
   logic        doWrite;
   logic        wrErr;
   logic        wrEn;
   logic        inCfg;
   logic [31:0] wMask;
   logic [31:0] wBits;
   logic [31:0] rdMux;

   assign awready = ~awHeld & ~bvalid;
   assign wready  = ~wHeld & ~bvalid;
   assign arready = ~rvalid;
   assign doWrite = awHeld & wHeld & ~bvalid;
   assign inCfg   = state == FRC_CONFIG;
   assign wrErr   = ~isMapped(wa) | (isLocked(wa) & ~inCfg);
   assign wrEn    = doWrite & ~wrErr;
   assign wMask   = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
   assign wBits   = wDataQ & wMask;

   logic wrCtrl;
   logic wrStat;
   logic wrEsc;
   logic swFunc;
   logic swDest;
   logic [NF-1:0] stClr;

   assign wrCtrl = wrEn & (wa == OFS_CTRL) & wStrbQ[0];
   assign wrStat = wrEn & (wa == OFS_STATUS);
   assign wrEsc  = wrEn & (wa == OFS_ESC_THR) & wStrbQ[0];
   assign swFunc = wrEn & (wa == OFS_RUN_CTRL) & wStrbQ[0] & (wDataQ[3:0] == RUN_FUNC);
   assign swDest = wrEn & (wa == OFS_RUN_CTRL) & wStrbQ[0] & (wDataQ[3:0] == RUN_DEST);
   assign stClr  = wrStat ? wBits[NF-1:0] : '0;

   assign rdMux =
      (araddr == OFS_CTRL)       ? {30'h0000_0000, state}    :
      (araddr == OFS_FAULT_EN)   ? 32'(faultEn)              :
      (araddr == OFS_REACTION)   ? 32'(reaction)             :
      (araddr == OFS_TIMEOUT_EN) ? 32'(toe)                  :
      (araddr == OFS_STATUS)     ? 32'(status)               :
      (araddr == OFS_EVT_DIS)    ? 32'(evtDis)               :
      (araddr == OFS_ALT_REQ)    ? 32'(altReq)               :
      (araddr == OFS_ESC_THR)    ? {24'h00_0000, escCnt, escThr} :
      (araddr == OFS_SAFE_CFG)   ? {30'h0000_0000, singlePin, pad_power_down} : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (rst) begin
         awHeld <= 1'b0;
         wa     <= '0;
      end else if (awvalid && awready) begin
         awHeld <= 1'b1;
         wa     <= awaddr;
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wHeld  <= 1'b0;
         wDataQ <= 32'h0000_0000;
         wStrbQ <= 4'h0;
      end else if (wvalid && wready) begin
         wHeld  <= 1'b1;
         wDataQ <= wdata;
         wStrbQ <= wstrb;
      end else if (doWrite) begin
         wHeld  <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp  <= wrErr ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= rdMux;
         rresp  <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Configuration registers; only power-on or destructive reset restores them.
   always_ff @(posedge clk) begin
      if (rst) begin
         faultEn  <= RST_FAULT_EN[NF-1:0];
         reaction <= RST_REACTION[2*NF-1:0];
         toe      <= RST_TOE[NF-1:0];
      end else if (wrEn) begin
         if (wa == OFS_FAULT_EN)   faultEn  <= (faultEn & ~wMask[NF-1:0]) | wBits[NF-1:0];
         if (wa == OFS_REACTION)   reaction <= (reaction & ~wMask[2*NF-1:0]) | wBits[2*NF-1:0];
         if (wa == OFS_TIMEOUT_EN) toe      <= (toe & ~wMask[NF-1:0]) | wBits[NF-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         evtDis    <= RST_EVT_DIS[NF-1:0];
         altReq    <= RST_ALT_REQ[NF-1:0];
         pad_power_down       <= 1'b0;
         singlePin <= 1'b0;
      end else if (wrEn) begin
         if (wa == OFS_EVT_DIS) evtDis <= (evtDis & ~wMask[NF-1:0]) | wBits[NF-1:0];
         if (wa == OFS_ALT_REQ) altReq <= (altReq & ~wMask[NF-1:0]) | wBits[NF-1:0];
         if (wa == OFS_SAFE_CFG && wStrbQ[0]) begin
            pad_power_down       <= wDataQ[SAFE_PDO_BIT];
            singlePin <= wDataQ[SAFE_SINGLE_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Fault collection and reaction decode.
   logic [NF-1:0] setVec;
   logic [NF-1:0] newSet;
   logic [NF-1:0] irqVec;
   logic [NF-1:0] nmiVec;
   logic [NF-1:0] frsVec;
   logic          toActive;
   logic          toFire;
   logic          frsFire;

   assign setVec = faultRaw & faultEn;
   assign newSet = setVec & ~status;

   for (genvar i = 0; i < NF; i++) begin : g_rx
      logic [1:0] sel;
      assign sel       = reaction[2*i +: 2];
      // A disabled reset event falls back to the selected alternate request.
      assign irqVec[i] = (sel == RX_IRQ) |
                         ((sel == RX_FRESET) & evtDis[i] & ~altReq[i]);
      assign nmiVec[i] = (sel == RX_NMI) |
                         ((sel == RX_FRESET) & evtDis[i] & altReq[i]);
      assign frsVec[i] = (sel == RX_FRESET) & ~evtDis[i];
   end

   // Configured reset reactions fire on a new flag only; toFire adds a reset when an IRQ or NMI flag with timeout enabled persists.
   assign frsFire  = (|(newSet & frsVec) & ~inCfg) | toFire;
   assign toActive = ~inCfg & |(status & toe & (irqVec | nmiVec));
   assign toFire   = toActive & (toCnt == 8'(FAULT_TIMEOUT_CYC - 1));

   always_ff @(posedge clk) begin
      if (rst) begin
         status <= '0;
      end else begin
         status <= (status & ~stClr) | setVec;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || funcRst || !toActive) begin
         toCnt <= 8'h00;
      end else if (toCnt != 8'(FAULT_TIMEOUT_CYC)) begin
         toCnt <= toCnt + 8'h01;
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         FRC_NORMAL: begin
            if (wrCtrl && wDataQ[CTRL_CFG_BIT]) next_state = FRC_CONFIG;
            else if (|status) next_state = FRC_FAULT;
         end
         FRC_CONFIG: begin
            if (wrCtrl && !wDataQ[CTRL_CFG_BIT]) next_state = (|status) ? FRC_FAULT : FRC_NORMAL;
         end
         FRC_FAULT: begin
            if (!(|status)) next_state = FRC_NORMAL;
         end
         default: next_state = FRC_NORMAL;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst || funcRst) begin
         state  <= FRC_NORMAL;
         irqReq <= 1'b0;
         nmiReq <= 1'b0;
         padHiZ <= 1'b0;
      end else begin
         state  <= next_state;
         irqReq <= ~inCfg & |(status & irqVec);
         nmiReq <= ~inCfg & |(status & nmiVec);
         padHiZ <= pad_power_down & (state == FRC_FAULT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Error pins; reporting has no enable so software cannot silence it.
   always_ff @(posedge clk) begin
      if (rst || funcRst) begin
         errLvl   <= 1'b0;
         errOeReg <= 2'b00;
      end else begin
         errLvl   <= |status;
         errOeReg <= {~singlePin, 1'b1};
      end
   end

   assign errOut   = {2{errLvl}};
   assign errOutOe = errOeReg & {2{~(rst | funcRst)}};

   ////////////////////////////////////////////////////////////////////////////////////////
   // Output supervisor.
   logic cfgExpire;
   logic reactExpire;
   logic supFire;

   assign cfgExpire   = cfgRcCnt == CFG_LIMIT_RC;
   assign reactExpire = reactCnt == REACT_LIMIT_CYC;
   assign supFire     = (cfgExpire | reactExpire) & ~supervisorRstReq;

   always_ff @(posedge clk) begin
      if (rst) begin
         rcPrev <= 1'b0;
      end else begin
         rcPrev <= pinsSync[NS-1];
      end
   end

   always_ff @(posedge clk) begin
      if (rst || funcRst || !inCfg) begin
         cfgRcCnt <= 13'h0000;
      end else if (rcEdge && !cfgExpire) begin
         cfgRcCnt <= cfgRcCnt + 13'h0001;
      end
   end

   // Watches only the flags and the pin level, so it stays independent of the reaction decode.
   always_ff @(posedge clk) begin
      if (rst || funcRst || !(|status) || errLvl) begin
         reactCnt <= 3'h0;
      end else if (!reactExpire) begin
         reactCnt <= reactCnt + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || funcRst) begin
         supervisorRstReq <= 1'b0;
      end else if (supFire) begin
         supervisorRstReq <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Reset generator with functional reset escalation.
   logic             funcEdge;
   logic             escOn;
   logic [ESC_W:0]   escCntInc;
   logic             escFire;

   assign funcEdge  = funcRst & ~funcRstPrev;
   assign escOn     = escThr != RST_ESC_THR;
   assign escCntInc = {1'b0, escCnt} + (ESC_W+1)'(1);
   assign escFire   = funcEdge & escOn & (escCntInc >= {1'b0, escThr});

   always_ff @(posedge clk) begin
      if (rst) begin
         funcRstPrev <= 1'b0;
         escThr      <= RST_ESC_THR;
         escCnt      <= '0;
      end else begin
         funcRstPrev <= funcRst;
         if (wrEsc) begin
            escThr <= wDataQ[ESC_W-1:0];
            escCnt <= '0;
         end else if (funcEdge && escOn && !escFire) begin
            escCnt <= escCntInc[ESC_W-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         funcResetReq <= 1'b0;
         destResetReq <= 1'b0;
      end else begin
         funcResetReq <= frsFire | swFunc | supFire;
         destResetReq <= swDest | escFire;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence sRunWrite(logic [3:0] v);
      wrEn && wa == OFS_RUN_CTRL && wStrbQ[0] && wDataQ[3:0] == v;
   endsequence

   sequence sLastFuncReset;
      funcEdge && escThr != 4'h0 && escCntInc == {1'b0, escThr};
   endsequence

   chk_cfg_write_lock: assert property (
      doWrite && isLocked(wa) && !inCfg |=> $stable(faultEn) && $stable(reaction)
         && $stable(toe) && bvalid && bresp == RESP_SLVERR)
      else $error("locked configuration register changed outside config state");
   chk_error_report: assert property (
      (|status) && !funcRst |=> errOut == 2'b11)
      else $error("active fault not reported on error pins");
   chk_pins_undriven: assert property (
      funcRst |-> errOutOe == 2'b00)
      else $error("error pins driven during reset");
   chk_single_pin: assert property (
      singlePin && $past(singlePin) && !funcRst && !$past(funcRst) |-> errOutOe == 2'b01)
      else $error("single pin mode must drive only error pin 0");
   chk_sw_func_reset: assert property (
      sRunWrite(RUN_FUNC) |=> funcResetReq && !destResetReq)
      else $error("run state 0000b did not request functional reset");
   chk_sw_dest_reset: assert property (
      sRunWrite(RUN_DEST) |=> destResetReq)
      else $error("run state 1111b did not request destructive reset");
   chk_esc_fire: assert property (
      sLastFuncReset |=> destResetReq ##1 !destResetReq)
      else $error("escalation threshold reached without destructive reset");
   chk_esc_clear: assert property (
      wrEsc |=> escCnt == '0 && escThr == $past(wDataQ[ESC_W-1:0]))
      else $error("escalation threshold write did not clear the counter");
   chk_cfg_limit: assert property (
      inCfg && !funcRst && cfgRcCnt == 13'h0FFF && rcEdge |=> ##1 supervisorRstReq)
      else $error("configuration time limit not enforced");
   chk_react_missing: assert property (
      ((|status) && !errLvl && !funcRst) [*5] |=> supervisorRstReq)
      else $error("supervisor missed an unreported fault");
   chk_fault_exit: assert property (
      state == FRC_FAULT && !(|status) && !funcRst |=> state == FRC_NORMAL)
      else $error("fault state kept after all flags cleared");
   chk_debug_fault: assert property (
      faultRaw[NF-1] && faultEn[NF-1] |=> status[NF-1])
      else $error("illegal debug entry not flagged");
endmodule : frc_fault_reset

// >>> verification/frc_monitor.sv
// Purpose: External monitor that watches the error pins.
// Assumes: A failure is a high level on an enabled error pin 0.
// Notes:   The safe state, once taken, holds until rst.
`timescale 1ns/1ps
module frc_monitor (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Error pins
   input  wire logic [1:0] errOut,
   input  wire logic [1:0] errOutOe,
   // Safe state
   output logic            safeState
);
   always_ff @(posedge clk) begin
      if (rst)
         safeState <= 1'b0;
      else if (errOutOe[0] && errOut[0])
         safeState <= 1'b1;
   end
endmodule : frc_monitor

// >>> verification/fault_collection_reset_escalation_tb_top.sv
// Purpose: Self-checking bench for the fault collector and reset generator.
// Assumes: AXI4-Lite master changes signals only after rising edges.
// Notes:   The supervisor test runs last since its request is sticky.
`timescale 1ns/1ps
module fault_collection_reset_escalation_tb_top;
   import frc_pkg::*;
   logic        clk = 0, rst = 1, funcRst = 0, tp = 0, de = 0, da = 0, rc = 0;
   logic [7:0]  fin = 0, awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  errOut, errOutOe, bresp, rresp, r;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, irq, nmi, fr, dr, sv, hiz, safe;
   int          n_mismatch = 0, compares = 0, nFr = 0, nDr = 0, n0;
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      nFr <= nFr + int'(fr);
      nDr <= nDr + int'(dr);
   end
   frc_fault_reset u_dut (.clk(clk), .rst(rst), .funcRst(funcRst), .faultIn(fin),
      .factoryTestPin(tp), .debugEnablePin(de), .debugActive(da), .internalRcOsc(rc),
      .errOut(errOut), .errOutOe(errOutOe), .irqReq(irq), .nmiReq(nmi), .funcResetReq(fr),
      .destResetReq(dr), .supervisorRstReq(sv), .padHiZ(hiz), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp));
   frc_monitor u_mon (.clk(clk), .rst(rst), .errOut(errOut), .errOutOe(errOutOe),
      .safeState(safe));
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask : chk
   task end_of_test;
      $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   // Each channel is released at the edge that takes it, sampled at the half cycle before.
   task wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      @(posedge clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
      tb = 0;
      while (!tb) begin
         @(negedge clk);
         {ta, tw, tb, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
         @(posedge clk);
         if (ta) awvalid <= 0;
         if (tw) wvalid <= 0;
      end
      bready <= 0;
   endtask : wr
   task rd(input logic [7:0] a);
      logic ta, tb;
      @(posedge clk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      tb = 0;
      while (!tb) begin
         @(negedge clk);
         {ta, tb, d, r} = {arvalid & arready, rvalid, rdata, rresp};
         @(posedge clk);
         if (ta) arvalid <= 0;
      end
      rready <= 0;
   endtask : rd
   task fpulse;
      @(posedge clk) funcRst <= 1;
      @(negedge clk) chk("oe in funcRst", errOutOe, 0);
      @(posedge clk) funcRst <= 0;
      repeat (4) @(posedge clk);
   endtask : fpulse
   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      end_of_test;
   end
   task test_config;
      rd(8'h40);
      chk("unmapped", r, RESP_SLVERR);
      wr(OFS_REACTION, 32'h1);
      chk("cfg locked", r, RESP_SLVERR);
      wr(OFS_CTRL, 32'h1);
      wr(OFS_REACTION, 32'h39);
      chk("cfg open", r, RESP_OKAY);
      wr(OFS_EVT_DIS, 32'h0);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_SAFE_CFG, 32'h3);
      repeat (3) @(posedge clk);
      chk("single pin", errOutOe, 2'b01);
      $display("config test done");
   endtask : test_config
   task test_faults;
      n0 = nFr;
      fin <= 8'h07;
      repeat (8) @(posedge clk);
      chk("err pins", errOut, 2'b11);
      chk("irq", irq, 1);
      chk("nmi", nmi, 1);
      chk("fault reset", nFr, n0 + 1);
      chk("pad hiz", hiz, 1);
      chk("monitor", safe, 1);
      fin <= 8'h00;
      repeat (6) @(posedge clk);
      chk("flag held", errOut, 2'b11);
      wr(OFS_STATUS, 32'h7);
      rd(OFS_CTRL);
      chk("state normal", d[1:0], 2'h0);
      chk("pins clear", errOut, 2'b00);
      {de, da} <= 2'b11;
      repeat (8) @(posedge clk);
      chk("debug allowed", errOut, 2'b00);
      {de, tp} <= 2'b01;
      repeat (8) @(posedge clk);
      chk("test and debug", errOut, 2'b11);
      {da, tp} <= 2'b00;
      wr(OFS_STATUS, 32'h300);
      $display("fault test done");
   endtask : test_faults
   task test_resets;
      n0 = nFr;
      wr(OFS_RUN_CTRL, {28'h0, RUN_FUNC});
      repeat (4) @(posedge clk);
      chk("sw func reset", nFr, n0 + 1);
      n0 = nDr;
      wr(OFS_RUN_CTRL, {28'h0, RUN_DEST});
      repeat (4) @(posedge clk);
      chk("sw dest reset", nDr, n0 + 1);
      n0 = nDr;
      repeat (3) fpulse;
      chk("esc off", nDr, n0);
      wr(OFS_ESC_THR, 32'h2);
      fpulse;
      chk("esc below", nDr, n0);
      fpulse;
      chk("esc fires", nDr, n0 + 1);
      fpulse;
      chk("esc held", nDr, n0 + 2);
      wr(OFS_ESC_THR, 32'h2);
      fpulse;
      chk("esc cleared", nDr, n0 + 2);
      $display("reset test done");
   endtask : test_resets
   task test_supervisor;
      wr(OFS_CTRL, 32'h1);
      for (n0 = 0; n0 < 4096; n0++) begin
         if (n0 == 4095) chk("sup early", sv, 0);
         repeat (2) @(posedge clk) rc <= 1;
         repeat (2) @(posedge clk) rc <= 0;
      end
      repeat (6) @(posedge clk);
      chk("sup fires", sv, 1);
      $display("supervisor test done");
   endtask : test_supervisor
   initial begin
      repeat (19) @(posedge clk);
      @(negedge clk) chk("oe in rst", errOutOe, 0);
      @(posedge clk) rst <= 0;
      test_config;
      test_faults;
      test_resets;
      test_supervisor;
      end_of_test;
   end
endmodule : fault_collection_reset_escalation_tb_top
